// ---- common/smcf_defines.svh ----
`ifndef SMCF_DEFINES_SVH
`define SMCF_DEFINES_SVH

// control bit positions inside the two control words
`define SMCF_POL_BIT        6
`define SMCF_MASTER_BIT     2
`define SMCF_PHASE_BIT      3

// word and divisor layout
`define SMCF_WORD_W         8
`define SMCF_MSB            7
`define SMCF_BITS_DONE      4'h8
`define SMCF_DIV_W          7

// divisor values up to and including this one all give the shortest period
`define SMCF_SMALL_DIV      7'h03
`define SMCF_MIN_PERIOD     8'h04
`define SMCF_MAX_PERIOD     8'h80
`define SMCF_ODD_MIN_PERIOD 8'h05
`define SMCF_ODD_MAX_PERIOD 8'h7F

// timing: core clock and the pad limit on the serial clock
`define SMCF_CLK_NS         100
`define SMCF_LINK_MAX_MHZ   20
`define SMCF_LINK_MIN_NS    (1000 / `SMCF_LINK_MAX_MHZ)
`define SMCF_LINK_MIN_CYC   ((`SMCF_LINK_MIN_NS + `SMCF_CLK_NS - 1) / `SMCF_CLK_NS)

// reset values
`define SMCF_SS_IDLE        1'b1
`define SMCF_SCLK_RST       1'b0

`endif

// ---- common/smcf_pkg.sv ----
package smcf_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_ACT,
        ST_REST,
        ST_TRAIL
    } smcf_state_t;

    typedef struct packed {
        smcf_state_t state;
        logic        ss;
        logic        active;
        logic        sclk;
        logic        mosi;
        logic [7:0]  sh;
        logic [3:0]  bitc;
        logic        busy;
        logic        rx_valid;
        logic [7:0]  rx;
        logic        miso_s1;
        logic        miso_s2;
        logic [7:0]  gap;
    } smcf_core_t;

    typedef struct packed {
        logic [6:0] cnt;
    } smcf_div_t;

endpackage

// ---- hw/smcf_baud_gen.sv ----
`timescale 1ns/10ps
`include "smcf_defines.svh"

module smcf_baud_gen
    import smcf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       next_long,
    input  wire logic [6:0] baud_divisor_field,
    output logic            tick,
    output logic [7:0]      period,
    output logic [6:0]      short_len,
    output logic [6:0]      long_len
);

    smcf_div_t s_q;
    smcf_div_t s_d;

    always_comb begin
        // small divisors fall back to the fixed shortest period
        if (baud_divisor_field <= `SMCF_SMALL_DIV) begin
            period = `SMCF_MIN_PERIOD;
        end else begin
            period = {1'b0, baud_divisor_field} + 8'h01;
        end
        // odd periods put the extra cycle into the idle-level half
        short_len = period[7:1];
        long_len  = period[7:1] + {6'h00, period[0]};
        tick      = run && (s_q.cnt == 7'h00);
        s_d       = s_q;
        if (!run) begin
            s_d.cnt = long_len - 7'h01;
        end else if (s_q.cnt == 7'h00) begin
            s_d.cnt = (next_long ? long_len : short_len) - 7'h01;
        end else begin
            s_d.cnt = s_q.cnt - 7'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// ---- hw/smcf_master.sv ----
// Overview of operation
// - serial period is four or divisor+1 clocks
// - odd period: idle half one clock longer
// - polarity bit six picks active edge
// - master set, phase clear: phase-0 master
// - phase 0 launches data on active edge
// - phase 0 samples on return edge
// - select low half period before first edge
// - select high half period after last clock edge
// - master set, phase set: phase-1 master
`timescale 1ns/10ps
`include "smcf_defines.svh"

module smcf_master
    import smcf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] configuration_control_register,
    input  wire logic [7:0] operation_control_register,
    input  wire logic [6:0] baud_divisor_field,
    input  wire logic       start,
    input  wire logic [7:0] tx_word,
    input  wire logic       master_in_line,
    output logic            serial_clock_pin,
    output logic            master_out_line,
    output logic            slave_select_out,
    output logic            busy,
    output logic            rx_valid,
    output logic [7:0]      rx_word
);

    smcf_core_t s_q;
    smcf_core_t s_d;
    logic       tick;
    logic [7:0] period;
    logic [6:0] short_len;
    logic [6:0] long_len;
    logic       pol;
    logic       is_master;
    logic       phase1;

    assign pol       = configuration_control_register[`SMCF_POL_BIT];
    assign is_master = operation_control_register[`SMCF_MASTER_BIT];
    assign phase1    = operation_control_register[`SMCF_PHASE_BIT];

    smcf_baud_gen u_baud (
        .clock              (clock),
        .rst                (rst),
        .run                (s_q.state != ST_IDLE),
        .next_long          (s_q.state == ST_ACT),
        .baud_divisor_field (baud_divisor_field),
        .tick               (tick),
        .period             (period),
        .short_len          (short_len),
        .long_len           (long_len)
    );

    always_comb begin
        s_d          = s_q;
        s_d.rx_valid = 1'b0;
        // miso crosses in from the pad; only the second stage is used
        s_d.miso_s1  = master_in_line;
        s_d.miso_s2  = s_q.miso_s1;
        case (s_q.state)
            ST_IDLE: begin
                // a start with the master bit clear is simply dropped
                if (start && is_master) begin
                    s_d.state = ST_LEAD;
                    s_d.ss    = 1'b0;
                    s_d.busy  = 1'b1;
                    s_d.sh    = tx_word;
                    s_d.mosi  = tx_word[`SMCF_MSB];
                    s_d.bitc  = 4'h0;
                end
            end
            ST_LEAD: begin
                if (tick) begin
                    s_d.state  = ST_ACT;
                    s_d.active = 1'b1;
                    if (phase1) begin
                        s_d.sh   = {s_q.sh[6:0], s_q.miso_s2};
                        s_d.bitc = s_q.bitc + 4'h1;
                    end
                end
            end
            ST_ACT: begin
                if (tick) begin
                    s_d.active = 1'b0;
                    if (!phase1) begin
                        s_d.sh   = {s_q.sh[6:0], s_q.miso_s2};
                        s_d.bitc = s_q.bitc + 4'h1;
                    end
                    if (s_d.bitc == `SMCF_BITS_DONE) begin
                        s_d.state = ST_TRAIL;
                    end else begin
                        s_d.state = ST_REST;
                        if (phase1) begin
                            s_d.mosi = s_q.sh[`SMCF_MSB];
                        end
                    end
                end
            end
            ST_REST: begin
                if (tick) begin
                    s_d.state  = ST_ACT;
                    s_d.active = 1'b1;
                    if (phase1) begin
                        s_d.sh   = {s_q.sh[6:0], s_q.miso_s2};
                        s_d.bitc = s_q.bitc + 4'h1;
                    end else begin
                        s_d.mosi = s_q.sh[`SMCF_MSB];
                    end
                end
            end
            ST_TRAIL: begin
                if (tick) begin
                    s_d.state    = ST_IDLE;
                    s_d.ss       = `SMCF_SS_IDLE;
                    s_d.busy     = 1'b0;
                    s_d.rx_valid = 1'b1;
                    s_d.rx       = s_q.sh;
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
        // the pin is the active flag seen through the polarity bit
        s_d.sclk = pol ^ s_d.active;
        // cycles since the pin or select last moved, only read by the checks below
        if ((s_q.sclk != s_d.sclk) || (s_q.ss != s_d.ss)) begin
            s_d.gap = 8'h01;
        end else begin
            s_d.gap = s_q.gap + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q       <= '0;
            s_q.state <= ST_IDLE;
            s_q.ss    <= `SMCF_SS_IDLE;
            s_q.sclk  <= `SMCF_SCLK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign serial_clock_pin = s_q.sclk;
    assign master_out_line  = s_q.mosi;
    assign slave_select_out = s_q.ss;
    assign busy             = s_q.busy;
    assign rx_valid         = s_q.rx_valid;
    assign rx_word          = s_q.rx;

    sequence s_frame_req;
        start && !busy && is_master;
    endsequence

    property p_period;
        @(posedge clock) disable iff (rst)
        (short_len + long_len) == ((baud_divisor_field <= `SMCF_SMALL_DIV) ?
            `SMCF_MIN_PERIOD : ({1'b0, baud_divisor_field} + 8'h01));
    endproperty
    a_period: assert property (p_period) else $error("serial period mismatch");

    property p_range;
        @(posedge clock) disable iff (rst)
        (period[0] && baud_divisor_field > `SMCF_SMALL_DIV) |->
            (period >= `SMCF_ODD_MIN_PERIOD && period <= `SMCF_ODD_MAX_PERIOD);
    endproperty
    a_range: assert property (p_range) else $error("odd period out of range");

    property p_half_asym;
        @(posedge clock) disable iff (rst)
        ($changed(serial_clock_pin) && $past(busy) && !$past(rst)) |->
            ($past(s_q.gap) == {1'b0, (s_q.active ? long_len : short_len)});
    endproperty
    a_half_asym: assert property (p_half_asym) else $error("half period wrong");

    property p_idle_level;
        @(posedge clock) disable iff (rst)
        (!busy && !$past(busy) && !$past(rst)) |-> serial_clock_pin == $past(pol);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

    property p_start;
        @(posedge clock) disable iff (rst)
        s_frame_req |=> (busy && !slave_select_out) ##1 (serial_clock_pin == $past(pol));
    endproperty
    a_start: assert property (p_start) else $error("master frame did not open");

    property p_no_master;
        @(posedge clock) disable iff (rst)
        (start && !busy && !is_master) |=> !busy && slave_select_out;
    endproperty
    a_no_master: assert property (p_no_master) else $error("frame without master");

    property p_launch_ph0;
        @(posedge clock) disable iff (rst)
        (!phase1 && busy && $past(busy) && !$past(rst) && $changed(master_out_line)) |->
            ($changed(serial_clock_pin) && s_q.active);
    endproperty
    a_launch_ph0: assert property (p_launch_ph0) else $error("launch off edge");

    property p_sample_ph0;
        @(posedge clock) disable iff (rst)
        (!phase1 && $past(busy) && !$past(rst) && $fell(s_q.active)) |->
            s_q.sh[0] == $past(s_q.miso_s2);
    endproperty
    a_sample_ph0: assert property (p_sample_ph0) else $error("sample off edge");

    property p_release;
        @(posedge clock) disable iff (rst)
        // a select rise forced by reset is not a word end
        ($rose(slave_select_out) && !$past(rst)) |->
            rx_valid && ($past(s_q.gap) == {1'b0, long_len});
    endproperty
    a_release: assert property (p_release) else $error("select release timing");

    property p_ss_low;
        @(posedge clock) disable iff (rst)
        busy == !slave_select_out;
    endproperty
    a_ss_low: assert property (p_ss_low) else $error("select level wrong");

endmodule

// ---- sim/smcf_slave.sv ----
`timescale 1ns/10ps
module smcf_slave (
    input  wire logic       serial_clock_pin,
    input  wire logic       slave_select_out,
    input  wire logic       master_out_line,
    input  wire logic       pol,
    input  wire logic       phase,
    input  wire logic [7:0] reply,
    output logic            master_in_line,
    output logic [7:0]      got
);
    logic [7:0] sh       = 8'h00;
    logic [7:0] got_q    = 8'h00;
    logic       line_q   = 1'h0;
    logic       ss_prev  = 1'h1;
    logic       pin_prev = 1'h0;
    assign master_in_line = line_q;
    assign got            = got_q;
    // one process owns the model state, so select and clock events never race
    always @(serial_clock_pin or slave_select_out) begin
        if (slave_select_out !== ss_prev) begin
            if (slave_select_out === 1'h0) begin
                // first bit ready at select fall, ahead of any sampling edge
                sh = reply;
                line_q = reply[7];
            end else begin
                // a released line must not keep its last bit
                line_q = ~line_q;
            end
        end else if (serial_clock_pin !== pin_prev && slave_select_out === 1'h0
                     && (serial_clock_pin ^ pol) === phase) begin
            // shift right after the shared sampling edge: a full period of setup
            got_q = {got_q[6:0], master_out_line};
            sh = {sh[6:0], 1'h0};
            line_q = sh[7];
        end
        ss_prev = slave_select_out;
        pin_prev = serial_clock_pin;
    end
endmodule

// ---- sim/spi_master_clock_framing_bench.sv ----
`timescale 1ns/10ps
`include "smcf_defines.svh"
module spi_master_clock_framing_bench;
    import smcf_pkg::*;
    typedef struct {
        logic       pol;
        logic       pha;
        logic [6:0] div;
        logic [7:0] tx;
        logic [7:0] rep;
        int         per;
    } smcf_row_t;
    logic       clock, rst, start, miso, sclk, mosi, ss, busy, rx_valid, pin_prev;
    logic [7:0] ccr, ocr, tx_word, rx_word, reply, got;
    logic [6:0] div;
    int         bad_count, n_tests, low_n, run, tail, s, l;
    int         runs[$];
    // divisors kept so the serial clock stays far below the pad limit
    smcf_row_t  rows[9] = '{'{1'h0, 1'h0, 7'h00, 8'hA5, 8'h3C, 4},
        '{1'h1, 1'h0, 7'h02, 8'h5A, 8'hC3, 4}, '{1'h0, 1'h0, 7'h03, 8'h81, 8'h7E, 4},
        '{1'h1, 1'h1, 7'h04, 8'h0F, 8'hF0, 5}, '{1'h0, 1'h1, 7'h09, 8'hC6, 8'h39, 10},
        '{1'h1, 1'h0, 7'h7E, 8'hFF, 8'h00, 127}, '{1'h0, 1'h1, 7'h7F, 8'h00, 8'hFF, 128},
        '{1'h0, 1'h0, 7'h06, 8'h96, 8'h69, 7}, '{1'h1, 1'h1, 7'h07, 8'h3C, 8'hA5, 8}};
    smcf_master uut (
        .clock                          (clock),
        .rst                            (rst),
        .configuration_control_register (ccr),
        .operation_control_register     (ocr),
        .baud_divisor_field             (div),
        .start                          (start),
        .tx_word                        (tx_word),
        .master_in_line                 (miso),
        .serial_clock_pin               (sclk),
        .master_out_line                (mosi),
        .slave_select_out               (ss),
        .busy                           (busy),
        .rx_valid                       (rx_valid),
        .rx_word                        (rx_word)
    );
    smcf_slave partner (
        .serial_clock_pin (sclk),
        .slave_select_out (ss),
        .master_out_line  (mosi),
        .pol              (ccr[`SMCF_POL_BIT]),
        .phase            (ocr[`SMCF_PHASE_BIT]),
        .reply            (reply),
        .master_in_line   (miso),
        .got              (got)
    );
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    // run lengths of the serial clock level while selected
    always @(negedge clock) begin
        if (ss === 1'h0) begin
            low_n++;
            if (sclk === pin_prev) run++;
            else begin
                runs.push_back(run);
                run = 1;
            end
        end else if (run != 0) begin
            tail = run;
            run = 0;
        end
        pin_prev = sclk;
    end
    task automatic cmp_v(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_n(input int g, input int e);
        n_tests++;
        if (g != e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic pulse();
        start = 1'h1;
        @(negedge clock);
        start = 1'h0;
    endtask
    task automatic word(input smcf_row_t r);
        int k;
        ccr = {1'h0, r.pol, 6'h00};
        ocr = {4'h0, r.pha, 3'h4};
        div = r.div;
        tx_word = r.tx;
        reply = r.rep;
        repeat (3) @(negedge clock);
        cmp_v({7'h00, sclk}, {7'h00, r.pol});
        low_n = 0;
        runs.delete();
        pulse();
        repeat (5) @(negedge clock);
        // a second request in mid-word must not restart the frame
        pulse();
        k = 0;
        while (rx_valid !== 1'h1 && k < 2000) begin
            @(negedge clock);
            k++;
        end
        cmp_v({7'h00, rx_valid}, 8'h01);
        @(negedge clock);
        cmp_v({7'h00, rx_valid}, 8'h00);
        s = r.per / 2;
        l = r.per - s;
        cmp_n(low_n, l + 8 * r.per);
        cmp_n(runs[0], l);
        cmp_n(runs[1], s);
        cmp_n(runs[2], l);
        cmp_n(runs.size(), 16);
        cmp_n(tail, l);
        cmp_v(rx_word, r.rep);
        cmp_v(got, r.tx);
        cmp_v({7'h00, ss}, 8'h01);
    endtask
    initial begin
        rst = 1'h1;
        start = 1'h0;
        ccr = 8'h00;
        ocr = 8'h04;
        div = 7'h00;
        tx_word = 8'h00;
        reply = 8'h00;
        {bad_count, n_tests, low_n, run, tail} = '0;
        repeat (12) @(negedge clock);
        cmp_v({2'h0, ss, busy, rx_valid, sclk, mosi, 1'h0}, 8'h20);
        cmp_v(rx_word, 8'h00);
        rst = 1'h0;
        foreach (rows[i]) word(rows[i]);
        ocr = 8'h00;
        pulse();
        repeat (4) @(negedge clock);
        cmp_v({6'h00, ss, busy}, 8'h02);
        ocr = 8'h04;
        pulse();
        repeat (8) @(negedge clock);
        cmp_v({6'h00, ss, busy}, 8'h01);
        rst = 1'h1;
        @(negedge clock);
        rst = 1'h0;
        cmp_v({6'h00, ss, busy}, 8'h02);
        word(rows[0]);
        wrap_up();
    end
    initial begin
        #2000000;
        bad_count++;
        wrap_up();
    end
endmodule
